// ---- hdl/trace_defines.svh ----
`ifndef TRACE_DEFINES_SVH
`define TRACE_DEFINES_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_WA_LO 8'h08
`define OFS_WA_HI 8'h0c
`define OFS_WB_LO 8'h10
`define OFS_WB_HI 8'h14
`define OFS_TB_IDX 8'h18
`define OFS_TB_SRC 8'h1c
`define OFS_TB_DST 8'h20
`define CTRL_RESET 32'h0000_0000
`define CTRL_WIDTH 12
// Internal branch buffer
`define TB_DEPTH 4'h8
`define TB_PTR_W 3
// Excluded reset jump target
`define RESET_JUMP_ADDR 32'ha000_0000
// System bus carries 28 address bits
`define SYS_ADDR_MASK 32'h0fff_ffff
// Data field nibble count, minus one
`define NIB_DATA 3'h7
`endif

// ---- hdl/trace_pkg.sv ----
package trace_pkg;
   typedef enum logic [1:0] {REC_BRANCH = 2'h0, REC_WINDOW = 2'h1, REC_SOFT = 2'h2} rec_type_e;
   typedef enum logic [1:0] {SZ_4 = 2'h0, SZ_8 = 2'h1, SZ_16 = 2'h2, SZ_32 = 2'h3} size_e;
   typedef enum {LINK_IDLE, LINK_HEAD, LINK_ADDR, LINK_DATA} link_state_e;
   typedef struct packed {
      logic nonrealtime;
      logic stop_on_full;
      logic branch_en;
      logic [1:0] win_en;
      logic soft_en;
      logic sys_bus;
      logic [1:0] qual_a;
      logic [1:0] qual_b;
      logic itrace_en;
   } ctrl_s;
   typedef struct packed {
      logic valid;
      logic [31:0] src;
      logic [31:0] dst;
      logic cond_zero_disp;
      logic reset_jump;
      logic exc_completion;
      logic [31:0] exc_next_pc;
   } branch_s;
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic write;
      logic cache_hit;
   } bus_s;
   typedef struct packed {
      logic valid;
      logic [31:0] pc;
      logic [31:0] data;
   } soft_s;
   typedef struct packed {
      rec_type_e rtype;
      size_e size;
      logic [31:0] addr;
      logic [31:0] data;
      logic has_data;
   } rec_s;
endpackage

// ---- hdl/on_chip_trace_unit.sv ----
// Function
// - Keep last eight branches internally
// - Realtime mode: never stall, drop records
// - Non-realtime mode: stall CPU while output pending
// - Continue policy: full buffer overwrites oldest
// - Stop policy: full buffer stops acquisition
// - Two window channels, range and qualifier
// - CPU-side bus: all CPU cycles, hits too
// - System bus: no hits, 28-bit address
// - Software trace: PC plus one register
// - Branch source compressed against previous source
// - Window address compressed against previous one
// - Upper 16/24/28 match sends low 16/8/4
// - Completion exception records next address
// - Internal buffer skips zero-displacement conditionals and reset jump
`timescale 1ns/1ps
`default_nettype none
`include "trace_defines.svh"
module on_chip_trace_unit
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic trace_port_clock,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire trace_pkg::branch_s branch_in,
   input wire trace_pkg::bus_s cpu_bus_in,
   input wire trace_pkg::bus_s sys_bus_in,
   input wire trace_pkg::soft_s soft_in,
   output logic cpu_stall,
   output logic [3:0] trace_port_data,
   output logic trace_port_sync
);
   import trace_pkg::*;
   ctrl_s ctrl;
   logic [31:0] win_lo [2];
   logic [31:0] win_hi [2];
   logic [`TB_PTR_W-1:0] tb_sel;
   logic [31:0] tb_src [`TB_DEPTH];
   logic [31:0] tb_dst [`TB_DEPTH];
   logic [`TB_PTR_W-1:0] tb_wptr;
   logic [3:0] tb_count;
   logic [7:0] drop_cnt;
   logic [31:0] prev_br;
   logic [31:0] prev_win;
   rec_s rec;
   logic req_tog;
   logic ak1, ak2, ak3, ack_seen;
   logic ack_tog;
   function automatic size_e compress(input logic [31:0] a, input logic [31:0] p);
      if (a[31:4] == p[31:4])
         return SZ_4;
      else if (a[31:8] == p[31:8])
         return SZ_8;
      else if (a[31:16] == p[31:16])
         return SZ_16;
      else
         return SZ_32;
   endfunction
   // Register writes
   wire wr_ctrl = reg_wr && reg_addr == `OFS_CTRL;
   wire wr_idx = reg_wr && reg_addr == `OFS_TB_IDX;
   wire [1:0] qual [2];
   assign qual[0] = ctrl.qual_a;
   assign qual[1] = ctrl.qual_b;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         ctrl <= ctrl_s'(`CTRL_WIDTH'(`CTRL_RESET));
      else if (wr_ctrl)
         ctrl <= ctrl_s'(reg_wdata[`CTRL_WIDTH-1:0]);
   end
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         tb_sel <= '0;
      else if (wr_idx)
         tb_sel <= reg_wdata[`TB_PTR_W-1:0];
   end
   // Observed bus: CPU side sees every CPU cycle, cache hits included;
   // system bus never sees hits and only 28 address bits
   wire obs_valid = ctrl.sys_bus ? (sys_bus_in.valid && !sys_bus_in.cache_hit)
                                 : cpu_bus_in.valid;
   wire [31:0] obs_addr = ctrl.sys_bus ? (sys_bus_in.addr & `SYS_ADDR_MASK)
                                       : cpu_bus_in.addr;
   wire obs_write = ctrl.sys_bus ? sys_bus_in.write : cpu_bus_in.write;
   wire [31:0] cmp_mask = ctrl.sys_bus ? `SYS_ADDR_MASK : 32'hffff_ffff;

   logic [1:0] win_hit;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_win
         wire [7:0] ofs_lo = (gi == 0) ? `OFS_WA_LO : `OFS_WB_LO;
         wire [7:0] ofs_hi = (gi == 0) ? `OFS_WA_HI : `OFS_WB_HI;
         wire [31:0] lo_m = win_lo[gi] & cmp_mask;
         wire [31:0] hi_m = win_hi[gi] & cmp_mask;
         wire qual_ok = obs_write ? qual[gi][1] : qual[gi][0];
         always_ff @(posedge core_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               win_lo[gi] <= 32'h0;
               win_hi[gi] <= 32'h0;
            end
            else if (reg_wr)
            begin
               if (reg_addr == ofs_lo)
                  win_lo[gi] <= reg_wdata;
               if (reg_addr == ofs_hi)
                  win_hi[gi] <= reg_wdata;
            end
         end
         assign win_hit[gi] = obs_valid && ctrl.win_en[gi] && qual_ok
                              && obs_addr >= lo_m && obs_addr <= hi_m;
      end
   endgenerate
   // Branch source after completion-type exception fix-up
   wire [31:0] br_src = branch_in.exc_completion ? branch_in.exc_next_pc : branch_in.src;
   wire br_ext = branch_in.valid && ctrl.branch_en;
   wire soft_ext = soft_in.valid && ctrl.soft_en;
   wire br_int_ok = branch_in.valid && ctrl.itrace_en && !branch_in.cond_zero_disp
                    && !(branch_in.reset_jump && branch_in.dst == `RESET_JUMP_ADDR);
   // Candidate record: branch first, then software, then window A, B
   wire cand_valid = br_ext || soft_ext || win_hit != 2'b00;
   wire [2:0] n_src = 3'(br_ext) + 3'(soft_ext) + 3'(win_hit[0]) + 3'(win_hit[1]);
   wire is_win = !br_ext && !soft_ext;
   wire [31:0] cand_addr = br_ext ? br_src : (soft_ext ? soft_in.pc : obs_addr);
   rec_s cand;
   always_comb
   begin
      cand = '0;
      if (br_ext)
      begin
         cand.rtype = REC_BRANCH;
         cand.size = compress(br_src, prev_br);
         cand.data = branch_in.dst;
         cand.has_data = 1'b1;
      end
      else if (soft_ext)
      begin
         cand.rtype = REC_SOFT;
         cand.size = SZ_32;
         cand.data = soft_in.data;
         cand.has_data = 1'b1;
      end
      else
      begin
         cand.rtype = REC_WINDOW;
         cand.size = compress(obs_addr, prev_win);
      end
      cand.addr = cand_addr;
   end
   // Handshake toward the trace-port domain
   wire next_ack_seen = (ak2 == ak3) ? ak3 : ack_seen;
   wire busy = req_tog != ack_seen;
   wire accept = cand_valid && !busy;
   // Realtime drops on busy; non-realtime stalls so only same-cycle losers drop
   wire [7:0] lost = 8'(busy ? n_src : (cand_valid ? n_src - 3'h1 : 3'h0));
   wire next_req = req_tog ^ accept;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ak1 <= 1'b0;
         ak2 <= 1'b0;
         ak3 <= 1'b0;
         ack_seen <= 1'b0;
      end
      else
      begin
         ak1 <= ack_tog;
         ak2 <= ak1;
         ak3 <= ak2;
         ack_seen <= next_ack_seen;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         req_tog <= 1'b0;
         rec <= '0;
         prev_br <= 32'h0;
         prev_win <= 32'h0;
         cpu_stall <= 1'b0;
      end
      else
      begin
         req_tog <= next_req;
         cpu_stall <= ctrl.nonrealtime && (next_req != next_ack_seen);
         if (accept)
         begin
            rec <= cand;
            if (br_ext)
               prev_br <= br_src;
            else if (is_win)
               prev_win <= obs_addr;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         drop_cnt <= 8'h0;
      else if (drop_cnt + lost > drop_cnt)
         drop_cnt <= drop_cnt + lost;
      else if (lost != 8'h0)
         drop_cnt <= 8'hff;
   end
   // Internal eight-entry branch ring
   wire tb_full = tb_count == `TB_DEPTH;
   wire tb_write = br_int_ok && !(tb_full && ctrl.stop_on_full);
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tb_wptr <= '0;
         tb_count <= 4'h0;
      end
      else if (tb_write)
      begin
         tb_wptr <= tb_wptr + 1'b1;
         if (!tb_full)
            tb_count <= tb_count + 4'h1;
      end
   end

   generate
      for (gi = 0; gi < `TB_DEPTH; gi++)
      begin : g_tb
         always_ff @(posedge core_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               tb_src[gi] <= 32'h0;
               tb_dst[gi] <= 32'h0;
            end
            else if (tb_write && tb_wptr == `TB_PTR_W'(gi))
            begin
               tb_src[gi] <= br_src;
               tb_dst[gi] <= branch_in.dst;
            end
         end
      end
   endgenerate
   // Index 0 reads the newest entry
   wire [`TB_PTR_W-1:0] tb_ridx = tb_wptr - tb_sel - 1'b1;
   wire [31:0] status = {16'h0, drop_cnt, 2'b00, busy, tb_full, tb_count};
   logic [31:0] rd_mux;
   always_comb
   begin
      case (reg_addr)
         `OFS_CTRL: rd_mux = 32'(ctrl);
         `OFS_STATUS: rd_mux = status;
         `OFS_WA_LO: rd_mux = win_lo[0];
         `OFS_WA_HI: rd_mux = win_hi[0];
         `OFS_WB_LO: rd_mux = win_lo[1];
         `OFS_WB_HI: rd_mux = win_hi[1];
         `OFS_TB_IDX: rd_mux = 32'(tb_sel);
         `OFS_TB_SRC: rd_mux = tb_src[tb_ridx];
         `OFS_TB_DST: rd_mux = tb_dst[tb_ridx];
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         reg_rdata <= 32'h0;
      else
         reg_rdata <= reg_rd ? rd_mux : 32'h0;
   end
   // Trace-port clock domain; the clock may stop between records
   logic lr1, lrst_n;
   logic rq1, rq2, rq3, req_seen;
   link_state_e lstate;
   rec_s lrec;
   logic [31:0] lsh;
   logic [2:0] lcnt;
   wire [2:0] addr_nibs = (lrec.size == SZ_4) ? 3'h0 : (lrec.size == SZ_8) ? 3'h1 :
                          (lrec.size == SZ_16) ? 3'h3 : 3'h7;

   always_ff @(posedge trace_port_clock or negedge nrst)
   begin
      if (!nrst)
      begin
         lr1 <= 1'b0;
         lrst_n <= 1'b0;
      end
      else
      begin
         lr1 <= 1'b1;
         lrst_n <= lr1;
      end
   end

   always_ff @(posedge trace_port_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         rq1 <= 1'b0;
         rq2 <= 1'b0;
         rq3 <= 1'b0;
         req_seen <= 1'b0;
      end
      else
      begin
         rq1 <= req_tog;
         rq2 <= rq1;
         rq3 <= rq2;
         if (rq2 == rq3)
            req_seen <= rq3;
      end
   end

   always_ff @(posedge trace_port_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         lstate <= LINK_IDLE;
         lrec <= '0;
         lsh <= 32'h0;
         lcnt <= 3'h0;
         ack_tog <= 1'b0;
         trace_port_data <= 4'h0;
         trace_port_sync <= 1'b0;
      end
      else
      begin
         case (lstate)
            LINK_IDLE:
            begin
               trace_port_data <= 4'h0;
               trace_port_sync <= 1'b0;
               if (req_seen != ack_tog)
               begin
                  lrec <= rec;
                  lstate <= LINK_HEAD;
               end
            end
            LINK_HEAD:
            begin
               trace_port_data <= {lrec.rtype, lrec.size};
               trace_port_sync <= 1'b1;
               lsh <= lrec.addr;
               lcnt <= 3'h0;
               lstate <= LINK_ADDR;
            end
            LINK_ADDR:
            begin
               trace_port_data <= lsh[3:0];
               trace_port_sync <= 1'b0;
               lsh <= {4'h0, lsh[31:4]};
               lcnt <= lcnt + 3'h1;
               if (lcnt == addr_nibs)
               begin
                  lcnt <= 3'h0;
                  lsh <= lrec.data;
                  if (lrec.has_data)
                     lstate <= LINK_DATA;
                  else
                  begin
                     ack_tog <= ~ack_tog;
                     lstate <= LINK_IDLE;
                  end
               end
            end
            LINK_DATA:
            begin
               trace_port_data <= lsh[3:0];
               trace_port_sync <= 1'b0;
               lsh <= {4'h0, lsh[31:4]};
               lcnt <= lcnt + 3'h1;
               if (lcnt == `NIB_DATA)
               begin
                  ack_tog <= ~ack_tog;
                  lstate <= LINK_IDLE;
               end
            end
            default:
               lstate <= LINK_IDLE;
         endcase
      end
   end
endmodule // on_chip_trace_unit
`default_nettype wire

// ---- testbench/trace_probe.sv ----
`timescale 1ns/1ps
`default_nettype none
module trace_probe
   import trace_pkg::*;
(
   input wire logic trace_port_clock,
   input wire logic [3:0] trace_port_data,
   input wire logic trace_port_sync
);
   rec_s q[$];
   rec_s cur;
   int n = 0;
   int k = 0;
   // Sampled like a flop: sees the nibble launched at the previous edge
   always @(posedge trace_port_clock)
   begin
      if (trace_port_sync)
      begin
         cur = '0;
         cur.rtype = rec_type_e'(trace_port_data[3:2]);
         cur.size = size_e'(trace_port_data[1:0]);
         cur.has_data = cur.rtype != REC_WINDOW;
         n = (1 << cur.size) + (cur.has_data ? 8 : 0);
         k = 0;
      end
      else if (k < n)
      begin
         if (k < (1 << cur.size))
            cur.addr[4*k +: 4] = trace_port_data;
         else
            cur.data[4*(k - (1 << cur.size)) +: 4] = trace_port_data;
         k++;
         if (k == n)
            q.push_back(cur);
      end
   end
endmodule // trace_probe
`default_nettype wire

// ---- testbench/trace_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "trace_defines.svh"
module trace_properties
   import trace_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic trace_port_clock,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire trace_pkg::branch_s branch_in,
   input wire trace_pkg::bus_s cpu_bus_in,
   input wire trace_pkg::bus_s sys_bus_in,
   input wire trace_pkg::soft_s soft_in,
   input wire logic cpu_stall,
   input wire logic [3:0] trace_port_data,
   input wire logic trace_port_sync
);
   logic nrt;
   logic ev;
   assign ev = branch_in.valid || soft_in.valid || cpu_bus_in.valid || sys_bus_in.valid;
   // Shadow of the stall mode bit, seen only through register writes
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
         nrt <= 1'b0;
      else if (reg_wr && reg_addr == `OFS_CTRL)
         nrt <= reg_wdata[11];
   read_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside answer cycle");
   unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_rd && reg_addr == 8'hfc |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
   ring_count_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_rd && reg_addr == `OFS_STATUS |=> reg_rdata[3:0] <= 4'h8) else $error("ring count over 8");
   ctrl_width_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_rd && reg_addr == `OFS_CTRL |=> reg_rdata[31:12] == 20'h0) else $error("ctrl reserved bits");
   realtime_nostall_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !nrt && !$past(nrt) |-> !cpu_stall) else $error("stall in realtime mode");
   stall_cause_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cpu_stall) |-> nrt && ($past(ev) || $past(ev, 2))) else $error("stall without event");
   stall_bound_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cpu_stall) |-> ##[1:300] !cpu_stall) else $error("stall never released");
   sync_single_a: assert property (@(posedge trace_port_clock) disable iff (!nrst)
      trace_port_sync |=> !trace_port_sync) else $error("header longer than one nibble");
   head_type_a: assert property (@(posedge trace_port_clock) disable iff (!nrst)
      trace_port_sync |-> trace_port_data[3:2] != 2'h3) else $error("unknown record type");
   soft_full_a: assert property (@(posedge trace_port_clock) disable iff (!nrst)
      trace_port_sync && trace_port_data[3:2] == 2'h2 |-> trace_port_data[1:0] == 2'h3)
      else $error("software record not full size");
endmodule // trace_properties
bind on_chip_trace_unit trace_properties u_trace_properties (.core_clk(core_clk), .nrst(nrst),
   .trace_port_clock(trace_port_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .branch_in(branch_in),
   .cpu_bus_in(cpu_bus_in), .sys_bus_in(sys_bus_in), .soft_in(soft_in),
   .cpu_stall(cpu_stall), .trace_port_data(trace_port_data),
   .trace_port_sync(trace_port_sync));
`default_nettype wire

// ---- testbench/on_chip_trace_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "trace_defines.svh"
module on_chip_trace_unit_bench;
   import trace_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_s;
   logic core_clk = 0, nrst = 0, trace_port_clock = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, v, pb = '0, pw = '0;
   branch_s branch_in = '0;
   bus_s cpu_bus_in = '0, sys_bus_in = '0;
   soft_s soft_in = '0;
   logic cpu_stall, trace_port_sync;
   logic [3:0] trace_port_data;
   int err_total = 0, checked = 0, cyc = 0;
   row_s rows[5] = '{'{`OFS_CTRL, 32'hffffffff, 32'h00000fff},
      '{`OFS_WA_LO, 32'h12345678, 32'h12345678}, '{`OFS_TB_IDX, 32'hffffffff, 32'h00000007},
      '{`OFS_TB_SRC, 32'hffffffff, 32'h0}, '{8'hfc, 32'hffffffff, 32'h0}};
   logic [31:0] srcs [5] = '{32'h12345678, 32'h12345690, 32'h1234569a, 32'h1234ffff,
      32'h9abc0000};
   always #12.5 core_clk = ~core_clk;
   // Free running so the link reset synchroniser always sees edges; 15.6 MHz
   initial #7 forever #32 trace_port_clock = ~trace_port_clock;
   on_chip_trace_unit u_on_chip_trace_unit (.core_clk, .nrst, .trace_port_clock, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .branch_in, .cpu_bus_in, .sys_bus_in,
      .soft_in, .cpu_stall, .trace_port_data, .trace_port_sync);
   trace_probe u_trace_probe (.trace_port_clock, .trace_port_data, .trace_port_sync);
   task give_verdict;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_total++;
         give_verdict;
      end
   end
   task chk(string n, logic [68:0] s, logic [68:0] e);
      checked++;
      if (s !== e)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task do_reset;
      nrst <= 1'b0;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge core_clk);
      pb = '0;
      pw = '0;
   endtask
   task wr(logic [7:0] a, logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      v = reg_rdata;
   endtask
   task br(logic [31:0] s, logic [31:0] d, logic [2:0] f);
      @(posedge core_clk);
      branch_in <= '{1'b1, s, d, f[2], f[1], f[0], s + 32'h2};
      @(posedge core_clk);
      branch_in <= '0;
   endtask
   task bus(logic sys, logic [31:0] a, logic w, logic hit);
      @(posedge core_clk);
      if (sys)
         sys_bus_in <= '{1'b1, a, w, hit};
      else
         cpu_bus_in <= '{1'b1, a, w, hit};
      @(posedge core_clk);
      sys_bus_in <= '0;
      cpu_bus_in <= '0;
   endtask
   function automatic rec_s er(rec_type_e t, logic [31:0] c, logic [31:0] p, logic [31:0] d);
      er = '0;
      er.rtype = t;
      if (t == REC_SOFT || c[31:16] != p[31:16])
         er.size = SZ_32;
      else if (c[31:8] != p[31:8])
         er.size = SZ_16;
      else if (c[31:4] != p[31:4])
         er.size = SZ_8;
      else
         er.size = SZ_4;
      er.addr = c & 32'((64'h1 << (4 << er.size)) - 64'h1);
      er.has_data = t != REC_WINDOW;
      er.data = er.has_data ? d : 32'h0;
   endfunction
   task chk_rec(rec_s e);
      int i;
      for (i = 0; i < 500 && u_trace_probe.q.size() == 0; i++)
         @(posedge core_clk);
      if (u_trace_probe.q.size() == 0)
         chk("record count", 1, 0);
      else
         chk("record", u_trace_probe.q.pop_front(), e);
   endtask
   task ring(logic [31:0] e0, logic [31:0] e7);
      int i;
      for (i = 1; i < 10; i++)
      begin
         br(32'h1000 + 16 * i, 32'h8000 + i, {2'b00, i == 9});
         if (i == 3)
            br(32'h3333, 32'h3335, 3'b100);
         if (i == 5)
            br(32'h5555, `RESET_JUMP_ADDR, 3'b010);
      end
      rd(`OFS_STATUS);
      chk("ring status", v[4:0], 5'h18);
      // The register rows leave the index on the oldest entry for the first call; reset leaves it at 0 for the second
      wr(`OFS_TB_IDX, 32'h0);
      rd(`OFS_TB_SRC);
      chk("newest source", v, e0);
      wr(`OFS_TB_IDX, 32'h7);
      rd(`OFS_TB_SRC);
      chk("oldest source", v, e7);
      $display("test ring done");
   endtask
   initial
   begin
      do_reset;
      chk("stall", cpu_stall, 1'b0);
      chk("sync", trace_port_sync, 1'b0);
      rd(`OFS_CTRL);
      chk("ctrl reset", v, `CTRL_RESET);
      rd(`OFS_STATUS);
      chk("status reset", v, 32'h0);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         chk("register row", v, rows[i].e);
      end
      $display("test registers done");
      wr(`OFS_CTRL, 32'h001);
      ring(32'h1092, 32'h1020);
      do_reset;
      wr(`OFS_CTRL, 32'h401);
      ring(32'h1080, 32'h1010);
      wr(`OFS_CTRL, 32'h240);
      foreach (srcs[i])
      begin
         v = srcs[i];
         br(v, 32'hcafe0000 + i, 3'b000);
         chk_rec(er(REC_BRANCH, v, pb, 32'hcafe0000 + i));
         pb = v;
      end
      @(posedge core_clk);
      soft_in <= '{1'b1, 32'h00000444, 32'hdeadbeef};
      @(posedge core_clk);
      soft_in <= '0;
      chk_rec(er(REC_SOFT, 32'h444, pb, 32'hdeadbeef));
      $display("test link done");
      wr(`OFS_WA_LO, 32'h2000);
      wr(`OFS_WA_HI, 32'h20ff);
      wr(`OFS_CTRL, 32'h088);
      bus(1'b0, 32'h2010, 1'b0, 1'b1);
      chk_rec(er(REC_WINDOW, 32'h2010, pw, 0));
      bus(1'b0, 32'h2020, 1'b1, 1'b0);
      bus(1'b0, 32'h3000, 1'b0, 1'b0);
      bus(1'b0, 32'h20ff, 1'b0, 1'b0);
      chk_rec(er(REC_WINDOW, 32'h20ff, 32'h2010, 0));
      wr(`OFS_WB_LO, 32'h4000);
      wr(`OFS_WB_HI, 32'h40ff);
      // Channel A holds the read window, channel B the write window
      wr(`OFS_CTRL, 32'h1ac);
      bus(1'b1, 32'hf0002050, 1'b0, 1'b0);
      chk_rec(er(REC_WINDOW, 32'h2050, 32'h20ff, 0));
      bus(1'b1, 32'h2060, 1'b0, 1'b1);
      bus(1'b1, 32'h4008, 1'b1, 1'b0);
      chk_rec(er(REC_WINDOW, 32'h4008, 32'h2050, 0));
      repeat (100) @(posedge core_clk);
      chk("stray records", u_trace_probe.q.size(), 0);
      $display("test window done");
      wr(`OFS_CTRL, 32'h200);
      br(32'h9abc0010, 32'h1, 3'b000);
      br(32'h9abc0020, 32'h2, 3'b000);
      chk_rec(er(REC_BRANCH, 32'h9abc0010, pb, 32'h1));
      pb = 32'h9abc0010;
      repeat (100) @(posedge core_clk);
      rd(`OFS_STATUS);
      chk("drop count", v[15:8], 8'h01);
      chk("lost record", u_trace_probe.q.size(), 0);
      wr(`OFS_CTRL, 32'ha00);
      br(32'h9abc0030, 32'h3, 3'b000);
      @(negedge core_clk);
      chk("stall raised", cpu_stall, 1'b1);
      for (int i = 0; i < 300 && cpu_stall !== 1'b0; i++)
         @(posedge core_clk);
      br(32'h9abc0040, 32'h4, 3'b000);
      chk_rec(er(REC_BRANCH, 32'h9abc0030, pb, 32'h3));
      chk_rec(er(REC_BRANCH, 32'h9abc0040, 32'h9abc0030, 32'h4));
      rd(`OFS_STATUS);
      chk("no new drops", v[15:8], 8'h01);
      $display("test stall done");
      give_verdict;
   end
endmodule // on_chip_trace_unit_bench
`default_nettype wire
